//--- hdl/mpcr_device.sv
// Purpose: Configuration register bank of the multi-rate PHY.
// Assumes: PCS status inputs come from logic on core_clk.
// Notes: Word-indexed bus; 16-bit registers sit in the low bits.
//
// Functional notes
// - Decode low, extended and loopback address ranges.
// - Low registers act only in 2.5G modes.
// - Host uses read-modify-write, avoids reserved registers.
// - Control bit 15 runs self-clearing soft reset.
// - Soft reset keeps all register contents.
// - Control bit 14 enables serial loopback.
// - Control bit 12 enables 1G auto-negotiation.
// - Control bit 9 restarts negotiation, self-clears.
// - Status bit 5 shows negotiation complete.
// - Status bit 3 reads one, capable.
// - Status bit 2 shows link up.
// - Offsets two, three return identifier value.
// - Advert bits 13:12 hold remote fault.
// - Advert bits 8:7 hold pause capability.
// - Host keeps full duplex bit set.
// - Reconfig sets rate, PLL, transceiver settings.
// - Reconfig then requests physical layer reset.
// - Precision-time option supplies latency to MAC.
`timescale 1ns/100ps
`include "mpcr_regs.svh"
module mpcr_device #(
  parameter mpcr_pkg::mpcr_mode_e OP_MODE = mpcr_pkg::MPCR_MODE_1G2G5, // Build mode.
  parameter bit PTP_EN = 1'b0, // Precision-time option built in.
  parameter logic [31:0] PHY_ID = 32'h0000_0000, // Identifier word.
  parameter logic [15:0] PTP_LATENCY = 16'h0010 // Latency figure, arbitrary default.
) (
  mpcr_if.dev bus, // Register bus and reconfiguration link.
  input wire logic rst, // Synchronous reset.
  input wire logic an_done_in, // Negotiation complete from the PCS.
  input wire logic link_up_in, // Link state from the PCS.
  output logic serial_loopback, // Serial loopback enable.
  output logic an_enable, // Auto-negotiation enable toward the PCS.
  output logic an_restart, // Restart pulse toward the PCS.
  output logic pcs_reset, // Datapath reset, level.
  output mpcr_pkg::mpcr_speed_e rate_sel, // Rate applied to the datapath.
  output logic [15:0] adv_word, // Ability word offered to the partner.
  output logic [15:0] ptp_latency // Latency toward the MAC.
);
  import mpcr_pkg::*;

  // The low register set only has meaning in the two 2.5G builds.
  localparam bit LOW_ACTIVE = (OP_MODE == MPCR_MODE_2G5) || (OP_MODE == MPCR_MODE_1G2G5);

  // The precision-time option exists only for the 2.5G builds.
  if (PTP_EN && !LOW_ACTIVE) begin : g_bad_ptp
    $error("Precision-time option needs a 2.5G build mode.");
  end
  if (`MPCR_SOFT_RST_CYC < 1 || `MPCR_SOFT_RST_CYC > 255) begin : g_bad_cnt
    $error("Soft reset count does not fit its counter.");
  end

  logic loopback_q; // Loopback control bit.
  logic anen_q; // Auto-negotiation enable bit.
  logic restart_q; // Restart request bit, reads back until begun.
  logic srst_busy_q; // Soft reset in progress.
  logic [7:0] srst_cnt_q; // Soft reset cycles left.
  logic [1:0] flt_q; // Remote fault code.
  logic [1:0] pause_q; // Pause capability.
  logic dplx_q; // Full duplex flag.
  logic [31:0] rdata_d; // Read mux output.
  logic wr_low; // Write that lands in the active low set.
  logic wr_ctrl; // Write to the control register.
  logic wr_adv; // Write to the ability word.
  logic srst_start; // Start of a soft reset.
  logic [15:0] ctrl_rd; // Control register as read.
  logic [15:0] stat_rd; // Status register as read.
  logic [15:0] adv_rd; // Ability word as read.

  // Writes only reach the low set in an active build; elsewhere they vanish.
  assign wr_low = bus.write && LOW_ACTIVE && (bus.address <= `MPCR_OFS_LOW_LAST);
  assign wr_ctrl = wr_low && (bus.address == `MPCR_OFS_CTRL);
  assign wr_adv = wr_low && (bus.address == `MPCR_OFS_ADV);

  // A soft reset comes from the control bit or from the reset controller.
  assign srst_start = (wr_ctrl && bus.writedata[`MPCR_CTRL_RST]) || bus.phy_reset_req;

  // Control bits. They are untouched by a soft reset, only rst clears them.
  always_ff @(posedge bus.core_clk) begin
    if (rst) begin
      loopback_q <= 1'b0;
      anen_q <= 1'b0;
    end else if (wr_ctrl) begin
      loopback_q <= bus.writedata[`MPCR_CTRL_LPBK];
      anen_q <= bus.writedata[`MPCR_CTRL_ANEN];
    end
  end

  // Restart request: held for one cycle, then cleared once the pulse goes out.
  // A new write in that same cycle sets it again, so no request is lost.
  always_ff @(posedge bus.core_clk) begin
    if (rst) begin
      restart_q <= 1'b0;
    end else if (wr_ctrl && bus.writedata[`MPCR_CTRL_ANRS]) begin
      restart_q <= 1'b1;
    end else begin
      restart_q <= 1'b0;
    end
  end

  // Soft reset timer. A new start while running reloads the count,
  // which stretches the reset rather than dropping the request.
  always_ff @(posedge bus.core_clk) begin
    if (rst) begin
      srst_busy_q <= 1'b0;
      srst_cnt_q <= 8'h00;
    end else if (srst_start) begin
      srst_busy_q <= 1'b1;
      srst_cnt_q <= 8'(`MPCR_SOFT_RST_CYC);
    end else if (srst_busy_q) begin
      srst_cnt_q <= srst_cnt_q - 8'h01;
      if (srst_cnt_q == 8'h01) begin
        srst_busy_q <= 1'b0; // The bit clears itself here.
      end
    end
  end

  // Advertised abilities; reserved bits of the word are never stored.
  always_ff @(posedge bus.core_clk) begin
    if (rst) begin
      flt_q <= 2'b00;
      pause_q <= 2'b00;
      dplx_q <= 1'b1; // Full duplex comes up set.
    end else if (wr_adv) begin
      flt_q <= bus.writedata[`MPCR_ADV_FLT_HI:`MPCR_ADV_FLT_LO];
      pause_q <= bus.writedata[`MPCR_ADV_PAUSE_HI:`MPCR_ADV_PAUSE_LO];
      dplx_q <= bus.writedata[`MPCR_ADV_DPLX]; // The host is trusted to keep this at one.
    end
  end

  // Read views of the 16-bit registers; every other bit stays zero.
  always_comb begin
    ctrl_rd = 16'h0000;
    ctrl_rd[`MPCR_CTRL_RST] = srst_busy_q;
    ctrl_rd[`MPCR_CTRL_LPBK] = loopback_q;
    ctrl_rd[`MPCR_CTRL_ANEN] = anen_q;
    ctrl_rd[`MPCR_CTRL_ANRS] = restart_q;
    stat_rd = 16'h0000;
    stat_rd[`MPCR_STAT_ANDONE] = an_done_in;
    stat_rd[`MPCR_STAT_ANABLE] = 1'b1;
    stat_rd[`MPCR_STAT_LINK] = link_up_in;
    adv_rd = 16'h0000;
    adv_rd[`MPCR_ADV_FLT_HI:`MPCR_ADV_FLT_LO] = flt_q;
    adv_rd[`MPCR_ADV_PAUSE_HI:`MPCR_ADV_PAUSE_LO] = pause_q;
    adv_rd[`MPCR_ADV_DPLX] = dplx_q;
  end

  // Address decode for reads. The extended and loopback ranges are decoded
  // but their contents live in a datapath this bank does not hold, so they
  // read zero; so does any address outside all three ranges.
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (LOW_ACTIVE && bus.address <= `MPCR_OFS_LOW_LAST) begin
      case (bus.address)
        `MPCR_OFS_CTRL: rdata_d = {16'h0000, ctrl_rd};
        `MPCR_OFS_STAT: rdata_d = {16'h0000, stat_rd};
        `MPCR_OFS_ID_LO: rdata_d = {16'h0000, PHY_ID[15:0]};
        `MPCR_OFS_ID_HI: rdata_d = {16'h0000, PHY_ID[31:16]};
        `MPCR_OFS_ADV: rdata_d = {16'h0000, adv_rd};
        default: rdata_d = 32'h0000_0000; // Undefined low registers.
      endcase
    end else if (bus.address >= `MPCR_OFS_USX_FIRST && bus.address <= `MPCR_OFS_USX_LAST) begin
      rdata_d = 32'h0000_0000; // Extended range.
    end else if (bus.address == `MPCR_OFS_SLB) begin
      rdata_d = 32'h0000_0000; // Serial loopback word.
    end
  end

  // Read answer: data and its strobe stand in the cycle after the read.
  always_ff @(posedge bus.core_clk) begin
    if (rst) begin
      bus.readdata <= 32'h0000_0000;
      bus.readdatavalid <= 1'b0;
    end else begin
      bus.readdatavalid <= bus.read;
      if (bus.read) begin
        bus.readdata <= rdata_d;
      end
    end
  end

  // Rate select is sampled once per cycle; it comes from logic on core_clk.
  always_ff @(posedge bus.core_clk) begin
    if (rst) begin
      rate_sel <= MPCR_SPD_1G;
    end else begin
      rate_sel <= bus.rate_select;
    end
  end

  // Datapath controls. The negotiation enable is only honoured at 1G; the restart pulse
  // is not gated by rate, so a stale enable left set at 2.5G can still send a restart there.
  always_ff @(posedge bus.core_clk) begin
    if (rst) begin
      serial_loopback <= 1'b0;
      an_enable <= 1'b0;
      an_restart <= 1'b0;
      pcs_reset <= 1'b0;
      adv_word <= `MPCR_ADV_RST;
    end else begin
      serial_loopback <= loopback_q && LOW_ACTIVE;
      an_enable <= anen_q && LOW_ACTIVE && (rate_sel == MPCR_SPD_1G);
      an_restart <= restart_q && anen_q && LOW_ACTIVE;
      pcs_reset <= srst_busy_q || srst_start; // Registers stay intact meanwhile.
      adv_word <= adv_rd;
    end
  end

  // Latency figure for the MAC; zero when the option is not built in.
  always_ff @(posedge bus.core_clk) begin
    if (rst) begin
      ptp_latency <= 16'h0000;
    end else begin
      ptp_latency <= (PTP_EN && LOW_ACTIVE) ? PTP_LATENCY : 16'h0000;
    end
  end

endmodule : mpcr_device

//--- hdl/mpcr_host.sv
// Purpose: Register host and reconfiguration sequencer.
// Assumes: Device answers every read one cycle later.
// Notes: All device writes are read-modify-write.
`timescale 1ns/100ps
`include "mpcr_regs.svh"
module mpcr_host (
  mpcr_if.host bus, // Device side.
  input wire logic rst, // Synchronous reset.
  input wire logic [2:0] usr_addr, // User register offset.
  input wire logic [31:0] usr_wdata, // User write data.
  input wire logic usr_wr, // User write strobe.
  input wire logic usr_rd, // User read strobe.
  output logic [31:0] usr_rdata, // User read data, next cycle.
  output logic pll_sel, // Selected transceiver PLL.
  output logic xcvr_cfg_busy // Transceiver being loaded.
);
  import mpcr_pkg::*;
  logic [10:0] tgt_q; // Target word offset.
  logic [31:0] wdat_q; // Data to merge.
  logic [31:0] mask_q; // Bits to change.
  logic [31:0] result_q; // Last read value.
  logic spd_pend_q; // Speed change follows the write.
  mpcr_speed_e speed_q; // Requested speed.
  mpcr_hst_e st_q; // Sequencer state.
  logic [7:0] cnt_q; // Configuration wait.
  logic [31:0] merged; // Read-modify-write result.
  logic busy; // Sequencer not idle.
  logic go_ok; // User order accepted.
  assign busy = (st_q != MPCR_H_IDLE);
  assign go_ok = usr_wr & ~busy;
  // Only masked bits change; full duplex stays set in the ability word.
  always_comb begin
    merged = (result_q & ~mask_q) | (wdat_q & mask_q);
    if (tgt_q == `MPCR_OFS_ADV) begin
      merged[`MPCR_ADV_DPLX] = 1'b1;
    end
  end
  // User-side set-up registers; ignored while a sequence runs.
  always_ff @(posedge bus.core_clk) begin
    if (rst) begin
      tgt_q <= 11'h000;
      wdat_q <= 32'h0;
      mask_q <= 32'h0;
      speed_q <= MPCR_SPD_1G;
    end else if (go_ok && usr_addr == `MPCR_H_ADDR) begin
      tgt_q <= usr_wdata[10:0];
    end else if (go_ok && usr_addr == `MPCR_H_WDATA) begin
      wdat_q <= usr_wdata;
    end else if (go_ok && usr_addr == `MPCR_H_MASK) begin
      mask_q <= usr_wdata;
    end else if (go_ok && usr_addr == `MPCR_H_SPEED) begin
      speed_q <= mpcr_speed_e'(usr_wdata[1:0]);
      tgt_q <= `MPCR_OFS_CTRL; // Off 1G, auto-negotiation is switched off first.
      wdat_q <= 32'h0;
      mask_q <= 32'h1 << `MPCR_CTRL_ANEN;
    end
  end
  // Sequencer: read, merge, write, then any speed change.
  always_ff @(posedge bus.core_clk) begin
    if (rst) begin
      st_q <= MPCR_H_IDLE;
      spd_pend_q <= 1'b0;
      cnt_q <= 8'h00;
    end else begin
      case (st_q)
        MPCR_H_IDLE: begin
          if (go_ok && usr_addr == `MPCR_H_GO && usr_wdata[1:0] != 2'b00) begin
            st_q <= MPCR_H_RD;
            spd_pend_q <= 1'b0;
          end else if (go_ok && usr_addr == `MPCR_H_SPEED) begin
            spd_pend_q <= 1'b1;
            st_q <= (usr_wdata[1:0] == MPCR_SPD_1G) ? MPCR_H_SET : MPCR_H_RD;
          end
        end
        MPCR_H_RD: st_q <= MPCR_H_RWAIT;
        MPCR_H_RWAIT: begin
          if (bus.readdatavalid) begin
            st_q <= (mask_q == 32'h0) ? MPCR_H_IDLE : MPCR_H_WR;
          end
        end
        MPCR_H_WR: st_q <= spd_pend_q ? MPCR_H_SET : MPCR_H_IDLE;
        MPCR_H_SET: begin
          st_q <= MPCR_H_CFG;
          cnt_q <= 8'(`MPCR_CFG_CYC);
        end
        MPCR_H_CFG: begin
          cnt_q <= cnt_q - 8'h01;
          if (cnt_q == 8'h01) begin
            st_q <= MPCR_H_RST;
          end
        end
        MPCR_H_RST: begin
          st_q <= MPCR_H_IDLE;
          spd_pend_q <= 1'b0;
        end
        default: st_q <= MPCR_H_IDLE;
      endcase
    end
  end
  // Bus strobes, rate select and reset request, all from flops.
  always_ff @(posedge bus.core_clk) begin
    if (rst) begin
      bus.read <= 1'b0;
      bus.write <= 1'b0;
      bus.address <= 11'h000;
      bus.writedata <= 32'h0;
      bus.rate_select <= MPCR_SPD_1G;
      bus.phy_reset_req <= 1'b0;
      pll_sel <= 1'b0;
      xcvr_cfg_busy <= 1'b0;
      result_q <= 32'h0;
    end else begin
      bus.read <= (st_q == MPCR_H_RD);
      bus.write <= (st_q == MPCR_H_WR);
      bus.address <= tgt_q;
      bus.writedata <= merged;
      bus.phy_reset_req <= (st_q == MPCR_H_RST);
      xcvr_cfg_busy <= (st_q == MPCR_H_CFG);
      if (st_q == MPCR_H_SET) begin
        bus.rate_select <= speed_q;
        pll_sel <= (speed_q != MPCR_SPD_1G);
      end
      if (st_q == MPCR_H_RWAIT && bus.readdatavalid) begin
        result_q <= bus.readdata;
      end
    end
  end
  // User read port.
  always_ff @(posedge bus.core_clk) begin
    if (rst) begin
      usr_rdata <= 32'h0;
    end else if (usr_rd) begin
      case (usr_addr)
        `MPCR_H_ADDR: usr_rdata <= {21'h0, tgt_q};
        `MPCR_H_WDATA: usr_rdata <= wdat_q;
        `MPCR_H_MASK: usr_rdata <= mask_q;
        `MPCR_H_RESULT: usr_rdata <= result_q;
        `MPCR_H_STATUS: usr_rdata <= {31'h0, busy};
        `MPCR_H_SPEED: usr_rdata <= {30'h0, speed_q};
        default: usr_rdata <= 32'h0;
      endcase
    end
  end
endmodule : mpcr_host

//--- hdl/mpcr_if.sv
// Purpose: Joins the register host and the device.
// Assumes: One clock, word addresses.
// Notes: Read data return one cycle after the read.
`timescale 1ns/100ps
interface mpcr_if (
  input logic core_clk // Shared clock.
);
  logic [10:0] address; // Word index.
  logic read; // Read strobe.
  logic write; // Write strobe.
  logic [31:0] writedata; // Write data.
  logic [31:0] readdata; // Read data.
  logic readdatavalid; // Read data strobe.
  mpcr_pkg::mpcr_speed_e rate_select; // Transceiver rate select.
  logic phy_reset_req; // Reset request pulse.
  modport dev (input core_clk, address, read, write, writedata, rate_select, phy_reset_req,
    output readdata, readdatavalid);
  modport host (input core_clk, readdata, readdatavalid,
    output address, read, write, writedata, rate_select, phy_reset_req);
endinterface : mpcr_if

//--- hdl/mpcr_pkg.sv
// Purpose: Types shared by both ends.
// Assumes: Nothing beyond the header.
// Notes: Encodings written out.
package mpcr_pkg;
  // Operating mode the core was built for.
  typedef enum logic [1:0] {
    MPCR_MODE_2G5 = 2'b00,
    MPCR_MODE_1G2G5 = 2'b01,
    MPCR_MODE_OTHER = 2'b10
  } mpcr_mode_e;
  // Transceiver rate select values.
  typedef enum logic [1:0] {
    MPCR_SPD_1G = 2'b00,
    MPCR_SPD_2G5 = 2'b01
  } mpcr_speed_e;
  // Host sequencer states.
  typedef enum logic [2:0] {
    MPCR_H_IDLE = 3'b000,
    MPCR_H_RD = 3'b001,
    MPCR_H_RWAIT = 3'b010,
    MPCR_H_WR = 3'b011,
    MPCR_H_SET = 3'b100,
    MPCR_H_CFG = 3'b101,
    MPCR_H_RST = 3'b110
  } mpcr_hst_e;
endpackage : mpcr_pkg

//--- hdl/mpcr_regs.svh
// Purpose: Offsets, field positions, reset values and timing counts.
// Assumes: Word-indexed register bus, 200 MHz core_clk.
// Notes: Definitions only.
`ifndef MPCR_REGS_SVH
`define MPCR_REGS_SVH
// Device word offsets (byte address is four times these).
`define MPCR_OFS_CTRL 11'h000
`define MPCR_OFS_STAT 11'h001
`define MPCR_OFS_ID_LO 11'h002
`define MPCR_OFS_ID_HI 11'h003
`define MPCR_OFS_ADV 11'h004
`define MPCR_OFS_LOW_LAST 11'h01F
`define MPCR_OFS_USX_FIRST 11'h400
`define MPCR_OFS_USX_LAST 11'h41F
`define MPCR_OFS_SLB 11'h461
// Control fields.
`define MPCR_CTRL_RST 15
`define MPCR_CTRL_LPBK 14
`define MPCR_CTRL_ANEN 12
`define MPCR_CTRL_ANRS 9
// Status fields.
`define MPCR_STAT_ANDONE 5
`define MPCR_STAT_ANABLE 3
`define MPCR_STAT_LINK 2
// Advertised-ability fields and reset value.
`define MPCR_ADV_FLT_HI 13
`define MPCR_ADV_FLT_LO 12
`define MPCR_ADV_PAUSE_HI 8
`define MPCR_ADV_PAUSE_LO 7
`define MPCR_ADV_DPLX 5
`define MPCR_ADV_MASK 16'h31A0
`define MPCR_ADV_RST 16'h0020
// Timing, printed time and derived cycle counts.
`define MPCR_CLK_NS 5
`define MPCR_SOFT_RST_NS 100
`define MPCR_SOFT_RST_CYC ((`MPCR_SOFT_RST_NS + `MPCR_CLK_NS - 1) / `MPCR_CLK_NS)
`define MPCR_CFG_NS 200
`define MPCR_CFG_CYC ((`MPCR_CFG_NS + `MPCR_CLK_NS - 1) / `MPCR_CLK_NS)
// Host user-side register offsets.
`define MPCR_H_ADDR 3'h0
`define MPCR_H_WDATA 3'h1
`define MPCR_H_MASK 3'h2
`define MPCR_H_GO 3'h3
`define MPCR_H_RESULT 3'h4
`define MPCR_H_STATUS 3'h5
`define MPCR_H_SPEED 3'h6
`endif

//--- sim/mpcr_properties.sv
// Purpose: Bus-level properties of the link between register host and device.
// Assumes: One clock domain, synchronous active-high reset.
// Notes: Watches only the interface signals, so both ends are judged together.
`timescale 1ns/100ps
`include "mpcr_regs.svh"
module mpcr_properties #(
  parameter logic [31:0] PHY_ID = 32'h0000_0000 // Identifier word the device was built with.
) (
  input wire logic core_clk, // Shared clock.
  input wire logic rst, // Synchronous reset.
  input wire logic [10:0] address, // Word index.
  input wire logic read, // Read strobe.
  input wire logic write, // Write strobe.
  input wire logic [31:0] writedata, // Write data.
  input wire logic [31:0] readdata, // Read data.
  input wire logic readdatavalid, // Read data strobe.
  input wire mpcr_pkg::mpcr_speed_e rate_select, // Transceiver rate select.
  input wire logic phy_reset_req // Reset request pulse.
);
  import mpcr_pkg::*;
  // One domain, so clock and reset are given once for every property.
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  // A read aimed at one word offset.
  sequence s_rd_at(logic [10:0] ofs);
    read && address == ofs;
  endsequence
  // A read anywhere in the extended or loopback ranges.
  sequence s_rd_ext;
    read && ((address >= `MPCR_OFS_USX_FIRST && address <= `MPCR_OFS_USX_LAST) || address == `MPCR_OFS_SLB);
  endsequence
  property p_read_answer;
    read |=> readdatavalid;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read not answered next cycle");
  property p_no_stray;
    !read |=> !readdatavalid;
  endproperty
  a_no_stray: assert property (p_no_stray) else $error("read data strobe without a read");
  property p_id_lo;
    s_rd_at(`MPCR_OFS_ID_LO) |=> readdata == {16'h0000, PHY_ID[15:0]};
  endproperty
  a_id_lo: assert property (p_id_lo) else $error("identifier low half wrong");
  property p_id_hi;
    s_rd_at(`MPCR_OFS_ID_HI) |=> readdata == {16'h0000, PHY_ID[31:16]};
  endproperty
  a_id_hi: assert property (p_id_hi) else $error("identifier high half wrong");
  property p_ext_zero;
    s_rd_ext |=> readdata == 32'h0000_0000;
  endproperty
  a_ext_zero: assert property (p_ext_zero) else $error("extended range read not zero");
  property p_capable;
    s_rd_at(`MPCR_OFS_STAT) |=> readdata[`MPCR_STAT_ANABLE] && readdata[31:6] == 26'h0;
  endproperty
  a_capable: assert property (p_capable) else $error("status capable bit or reserved bits wrong");
  property p_adv_res;
    s_rd_at(`MPCR_OFS_ADV) |=> (readdata & ~{16'h0000, `MPCR_ADV_MASK}) == 32'h0000_0000;
  endproperty
  a_adv_res: assert property (p_adv_res) else $error("ability word reserved bits not zero");
  property p_wr_legal;
    write |-> address == `MPCR_OFS_CTRL || address == `MPCR_OFS_ADV;
  endproperty
  a_wr_legal: assert property (p_wr_legal) else $error("host wrote a read-only or undefined place");
  property p_fd_kept;
    write && address == `MPCR_OFS_ADV |-> writedata[`MPCR_ADV_DPLX];
  endproperty
  a_fd_kept: assert property (p_fd_kept) else $error("host cleared the full duplex bit");
  property p_an_off;
    write && address == `MPCR_OFS_CTRL && rate_select != MPCR_SPD_1G |-> !writedata[`MPCR_CTRL_ANEN];
  endproperty
  a_an_off: assert property (p_an_off) else $error("negotiation enabled away from 1G");
  property p_reset_req;
    $changed(rate_select) |-> ##[38:46] phy_reset_req;
  endproperty
  a_reset_req: assert property (p_reset_req) else $error("no reset request after rate change");
endmodule : mpcr_properties

//--- sim/tb_top.sv
// Purpose: Self-checking bench for the host and device joined by their link.
// Assumes: 200 MHz core_clk, reset held four cycles, host sequencer reaches the device.
// Notes: A small model in integers predicts every register read and output.
`timescale 1ns/100ps
`include "mpcr_regs.svh"
module tb_top;
  import mpcr_pkg::*;
  localparam logic [31:0] TB_ID = 32'h5A3C_0F96; // Arbitrary identifier value.
  logic core_clk = 1'b0; // Clock.
  logic rst = 1'b1; // Reset.
  logic [2:0] usr_addr = 3'h0; // User offset.
  logic [31:0] usr_wdata = 32'h0; // User write data.
  logic usr_wr = 1'b0; // User write strobe.
  logic usr_rd = 1'b0; // User read strobe.
  logic an_done_in = 1'b0; // Negotiation done.
  logic link_up_in = 1'b0; // Link state.
  logic [31:0] usr_rdata; // User read data.
  logic pll_sel, xcvr_cfg_busy, serial_loopback, an_enable, an_restart, pcs_reset; // Outputs.
  mpcr_speed_e rate_sel; // Applied rate.
  logic [15:0] adv_word, ptp_latency; // Output words.
  logic [15:0] adv_m = 16'h0020; // Model of the ability word.
  integer num_errors = 0; // Mismatches.
  integer compares = 0; // Comparisons made.
  integer seed = 32'hCDF5F9F0; // Random seed.
  integer cycles = 0; // Hang guard.
  integer restarts = 0; // Restart pulses seen.
  integer rst_hi = 0; // Cycles with datapath reset high.
  integer cfg_hi = 0; // Cycles with transceiver load busy.
  wire logic [15:0] flags = {10'h0, serial_loopback, an_enable, pll_sel, xcvr_cfg_busy, rate_sel}; // Level outputs.
  // The clock runs free.
  initial begin
    forever #2.5 core_clk = ~core_clk;
  end
  mpcr_if i_mpcr_if (.core_clk(core_clk));
  mpcr_host i_mpcr_host (.bus(i_mpcr_if), .rst(rst), .usr_addr(usr_addr), .usr_wdata(usr_wdata),
    .usr_wr(usr_wr), .usr_rd(usr_rd), .usr_rdata(usr_rdata), .pll_sel(pll_sel), .xcvr_cfg_busy(xcvr_cfg_busy));
  mpcr_device #(.PHY_ID(TB_ID)) i_mpcr_device (.bus(i_mpcr_if), .rst(rst), .an_done_in(an_done_in),
    .link_up_in(link_up_in), .serial_loopback(serial_loopback), .an_enable(an_enable), .an_restart(an_restart),
    .pcs_reset(pcs_reset), .rate_sel(rate_sel), .adv_word(adv_word), .ptp_latency(ptp_latency));
  mpcr_properties #(.PHY_ID(TB_ID)) i_mpcr_properties (.core_clk(core_clk), .rst(rst),
    .address(i_mpcr_if.address), .read(i_mpcr_if.read), .write(i_mpcr_if.write),
    .writedata(i_mpcr_if.writedata), .readdata(i_mpcr_if.readdata), .readdatavalid(i_mpcr_if.readdatavalid),
    .rate_select(i_mpcr_if.rate_select), .phy_reset_req(i_mpcr_if.phy_reset_req));
  // Counts cycles and the pulses that a bus read cannot catch.
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (an_restart === 1'b1) begin
      restarts <= restarts + 1;
    end
    if (pcs_reset === 1'b1) begin
      rst_hi <= rst_hi + 1;
    end
    if (xcvr_cfg_busy === 1'b1) begin
      cfg_hi <= cfg_hi + 1;
    end
  end
  // One compare per kind of result: register words and output words.
  task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_word
  task automatic chk_pin(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_pin
  // User port cycles; each ends just after an edge with its strobe low.
  task automatic uwr(input logic [2:0] a, input logic [31:0] d);
    usr_addr <= a;
    usr_wdata <= d;
    usr_wr <= 1'b1;
    @(posedge core_clk);
    usr_wr <= 1'b0;
    @(posedge core_clk);
  endtask : uwr
  task automatic urd(input logic [2:0] a, output logic [31:0] d);
    usr_addr <= a;
    usr_rd <= 1'b1;
    @(posedge core_clk);
    usr_rd <= 1'b0;
    @(posedge core_clk);
    d = usr_rdata;
  endtask : urd
  // Polls the busy flag; the first two cycles let the sequencer leave idle.
  task automatic wait_idle;
    logic [31:0] s;
    integer n = 0;
    repeat (2) @(posedge core_clk);
    do begin
      urd(`MPCR_H_STATUS, s);
      n++;
    end while (s[0] !== 1'b0 && n < 200);
    if (s[0] !== 1'b0) begin
      num_errors++;
      $display("mismatch host_busy expected 0 seen %b", s[0]);
    end
  endtask : wait_idle
  // A read-modify-write through the host; a zero mask makes it a plain read.
  task automatic dev_op(input logic [10:0] a, input logic [31:0] d, input logic [31:0] m, output logic [31:0] r);
    uwr(`MPCR_H_ADDR, {21'h0, a});
    uwr(`MPCR_H_WDATA, d);
    uwr(`MPCR_H_MASK, m);
    uwr(`MPCR_H_GO, 32'h1);
    wait_idle();
    urd(`MPCR_H_RESULT, r);
  endtask : dev_op
  task automatic rd_chk(input string what, input logic [10:0] a, input logic [31:0] exp);
    logic [31:0] r;
    dev_op(a, 32'h0, 32'h0, r);
    chk_word(what, exp, r);
  endtask : rd_chk
  task automatic tally_and_finish;
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : tally_and_finish
  // A hang counts as a mismatch and still reaches the report.
  initial begin
    wait (cycles >= 20000);
    num_errors++;
    $display("mismatch run_length expected done seen hang");
    tally_and_finish();
  end
  // Main sequence.
  initial begin
    logic [31:0] r;
    logic [15:0] v;
    logic [10:0] ext [4];
    integer i;
    ext = '{11'h010, `MPCR_OFS_USX_FIRST, `MPCR_OFS_USX_LAST, `MPCR_OFS_SLB};
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    rd_chk("ctrl", `MPCR_OFS_CTRL, 32'h0);
    chk_pin("flags", 16'h0, flags);
    for (i = 0; i < 4; i++) begin
      an_done_in <= i[1];
      link_up_in <= i[0];
      rd_chk("status", `MPCR_OFS_STAT, {26'h0, i[1], 2'b01, i[0], 2'b00});
    end
    rd_chk("id_lo", `MPCR_OFS_ID_LO, {16'h0, TB_ID[15:0]});
    rd_chk("id_hi", `MPCR_OFS_ID_HI, {16'h0, TB_ID[31:16]});
    rd_chk("advert", `MPCR_OFS_ADV, 32'h0020);
    chk_pin("ptp_latency", 16'h0, ptp_latency);
    // Every fault and pause code, with random reserved bits that must not stick.
    for (i = 0; i < 4; i++) begin
      v = 16'($random(seed));
      v[13:12] = i[1:0];
      v[8:7] = i[1:0];
      dev_op(`MPCR_OFS_ADV, {16'h0, v}, 32'hFFFF, r);
      adv_m = (v & `MPCR_ADV_MASK) | 16'h0020;
      rd_chk("advert", `MPCR_OFS_ADV, {16'h0, adv_m});
      chk_pin("adv_word", adv_m, adv_word);
    end
    dev_op(`MPCR_OFS_CTRL, 32'h5000, 32'hFFFF, r);
    rd_chk("ctrl", `MPCR_OFS_CTRL, 32'h5000);
    chk_pin("flags", 16'h0030, flags);
    i = restarts;
    dev_op(`MPCR_OFS_CTRL, 32'h0200, 32'h0200, r);
    chk_word("restarts", 32'(i + 1), 32'(restarts));
    rd_chk("ctrl", `MPCR_OFS_CTRL, 32'h5000);
    // Soft reset clears itself and leaves every register alone.
    i = rst_hi;
    dev_op(`MPCR_OFS_CTRL, 32'h8000, 32'h8000, r);
    repeat (`MPCR_SOFT_RST_CYC + 4) @(posedge core_clk);
    chk_word("soft_reset_len", 32'(`MPCR_SOFT_RST_CYC + 1), 32'(rst_hi - i));
    rd_chk("ctrl", `MPCR_OFS_CTRL, 32'h5000);
    rd_chk("advert", `MPCR_OFS_ADV, {16'h0, adv_m});
    for (i = 0; i < 4; i++) begin
      rd_chk("unmapped", ext[i], 32'h0);
    end
    // Speed change to 2.5G: negotiation off, new rate and PLL, then a datapath reset.
    i = rst_hi;
    uwr(`MPCR_H_SPEED, 32'h1);
    wait_idle();
    chk_pin("flags", 16'h0029, flags);
    repeat (`MPCR_SOFT_RST_CYC + 4) @(posedge core_clk);
    chk_word("speed_reset_len", 32'(`MPCR_SOFT_RST_CYC + 1), 32'(rst_hi - i));
    // A control write away from 1G must keep negotiation off; the restart finds nothing to restart.
    dev_op(`MPCR_OFS_CTRL, 32'h0200, 32'h0200, r);
    rd_chk("ctrl", `MPCR_OFS_CTRL, 32'h4000);
    uwr(`MPCR_H_SPEED, 32'h0);
    wait_idle();
    repeat (`MPCR_SOFT_RST_CYC + 4) @(posedge core_clk);
    chk_pin("flags", 16'h0020, flags);
    chk_word("cfg_len", 32'(2 * `MPCR_CFG_CYC), 32'(cfg_hi));
    tally_and_finish();
  end
endmodule : tb_top
